// ### dacrc_pkg.sv
// Purpose: shared constants and types for the dac register control block
// Assumes: 8-bit register port, byte offsets as mapped
// Notes: none
package dacrc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [1:0] DACRC_OFS_CTRL = 2'h0;
  localparam logic [1:0] DACRC_OFS_RSVD = 2'h1;
  localparam logic [1:0] DACRC_OFS_LEFT = 2'h2;
  localparam logic [1:0] DACRC_OFS_RIGHT = 2'h3;
  localparam int DACRC_AW = 2;
  localparam int DACRC_DW = 8;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int DACRC_B_ENABLE = 7;
  localparam int DACRC_B_TEST = 6;
  localparam int DACRC_B_ALIGN = 3;
  localparam int DACRC_B_SIGNED = 2;
  localparam int DACRC_B_WAITPD = 1;
  localparam int DACRC_B_PINOE = 0;
  localparam logic [7:0] DACRC_CTRL_RST = 8'h00;
  localparam logic [7:0] DACRC_CTRL_WMASK = 8'hCF;
  localparam logic [7:0] DACRC_VALUE_RST = 8'h00;
  localparam logic [7:0] DACRC_ZERO = 8'h00;

  typedef struct packed {
    logic enable;
    logic test;
    logic align;
    logic signed_fmt;
    logic wait_pd;
    logic pin_oe;
  } dacrc_ctrl_t;

  typedef struct packed {
    logic [7:0] code;
    logic power_up;
    logic pin_oe;
    logic test;
  } dacrc_core_t;

  typedef enum logic [2:0] {
    DACRC_OFF = 3'b001,
    DACRC_RUN = 3'b010,
    DACRC_HOLD = 3'b100
  } dacrc_state_t;
endpackage : dacrc_pkg

// ### dacrc_sync.sv
// Purpose: two flip-flop synchroniser for an asynchronous level
// Assumes: reset already synchronised by the caller where needed
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module dacrc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : dacrc_sync

// ### dacrc_code.sv
// Purpose: turn the stored byte into the unsigned code for the analog core
// Assumes: combinational, same clock as caller
// Notes: signed two's complement maps by flipping the top bit
`timescale 1ns/1ps
module dacrc_code (
  input wire logic [7:0] value,
  input wire logic signed_fmt,
  output logic [7:0] code
);
  // $7f -> $ff, $80 -> $00 in signed form
  assign code = {value[7] ^ signed_fmt, value[6:0]};
endmodule : dacrc_code

// ### dacrc_top.sv
// Purpose: control side of an 8-bit single-channel d/a converter
// Assumes: ref_clk 25 MHz, mode inputs come from outside the clock domain
// Notes: analog pin is modelled as code, power and output enable to the core
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module dacrc_top
  import dacrc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [DACRC_AW-1:0] reg_addr,
  input wire logic [DACRC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DACRC_DW-1:0] reg_rdata,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic [7:0] core_code,
  output logic core_power_up,
  output logic core_test,
  output logic analog_output_pin_oe
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  // arst_n takes hold at once but lets go through two flops, so no register
  // leaves reset on an edge that falls close to the rise of the pin
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // mode synchronisers
  // ----------------------------------------
  // chip mode levels come from another domain; each costs two cycles
  localparam int MODE_N = 3;
  localparam int MODE_SPECIAL = 0;
  localparam int MODE_WAIT = 1;
  localparam int MODE_STOP = 2;
  logic [MODE_N-1:0] mode_raw;
  logic [MODE_N-1:0] mode_s;
  assign mode_raw[MODE_SPECIAL] = special_mode;
  assign mode_raw[MODE_WAIT] = wait_mode;
  assign mode_raw[MODE_STOP] = stop_mode;
  generate
    for (genvar gi = 0; gi < MODE_N; gi++) begin : g_mode_sync
      dacrc_sync u_sync (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .din(mode_raw[gi]),
        .dout(mode_s[gi])
      );
    end
  endgenerate

  logic special_s;
  logic wait_s;
  logic stop_s;
  assign special_s = mode_s[MODE_SPECIAL];
  assign wait_s = mode_s[MODE_WAIT];
  assign stop_s = mode_s[MODE_STOP];

  // ----------------------------------------
  // stored state
  // ----------------------------------------
  dacrc_ctrl_t ctrl_q;
  dacrc_ctrl_t ctrl_d;
  logic [7:0] value_q;
  logic [7:0] value_d;

  // reset image of the control fields, taken from the register reset word
  localparam dacrc_ctrl_t CTRL_RST_T = '{
    enable: DACRC_CTRL_RST[DACRC_B_ENABLE],
    test: DACRC_CTRL_RST[DACRC_B_TEST],
    align: DACRC_CTRL_RST[DACRC_B_ALIGN],
    signed_fmt: DACRC_CTRL_RST[DACRC_B_SIGNED],
    wait_pd: DACRC_CTRL_RST[DACRC_B_WAITPD],
    pin_oe: DACRC_CTRL_RST[DACRC_B_PINOE]
  };

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic sel_ctrl;
  logic sel_rsvd;
  logic sel_left;
  logic sel_right;
  assign sel_ctrl = (reg_addr == DACRC_OFS_CTRL);
  assign sel_rsvd = (reg_addr == DACRC_OFS_RSVD);
  assign sel_left = (reg_addr == DACRC_OFS_LEFT);
  assign sel_right = (reg_addr == DACRC_OFS_RIGHT);

  // exactly one data view is live; the other reads zero and drops writes
  logic view_left_live;
  logic view_right_live;
  assign view_left_live = !ctrl_q.align;
  assign view_right_live = ctrl_q.align;

  logic wr_ctrl;
  logic wr_left;
  logic wr_right;
  logic wr_value;
  assign wr_ctrl = reg_wr && sel_ctrl;
  // the inactive view ignores writes, so the byte survives a view change
  assign wr_left = reg_wr && sel_left && view_left_live;
  assign wr_right = reg_wr && sel_right && view_right_live;
  assign wr_value = wr_left || wr_right;

  // ----------------------------------------
  // control field update
  // ----------------------------------------
  logic [7:0] wr_masked;
  assign wr_masked = reg_wdata & DACRC_CTRL_WMASK;
  // test bit only moves in special modes; elsewhere a write leaves it alone
  logic wr_test_ok;
  assign wr_test_ok = wr_ctrl && special_s;
  assign ctrl_d.enable = wr_ctrl ? wr_masked[DACRC_B_ENABLE] : ctrl_q.enable;
  assign ctrl_d.test = wr_test_ok ? wr_masked[DACRC_B_TEST] : ctrl_q.test;
  assign ctrl_d.align = wr_ctrl ? wr_masked[DACRC_B_ALIGN] : ctrl_q.align;
  assign ctrl_d.signed_fmt = wr_ctrl ? wr_masked[DACRC_B_SIGNED] : ctrl_q.signed_fmt;
  assign ctrl_d.wait_pd = wr_ctrl ? wr_masked[DACRC_B_WAITPD] : ctrl_q.wait_pd;
  assign ctrl_d.pin_oe = wr_ctrl ? wr_masked[DACRC_B_PINOE] : ctrl_q.pin_oe;
  assign value_d = wr_value ? reg_wdata : value_q;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // stop mode leaves these untouched: only the core is gated
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= CTRL_RST_T;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      value_q <= DACRC_VALUE_RST;
    end else begin
      value_q <= value_d;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] ctrl_rd;
  logic [7:0] rsvd_rd;
  logic [7:0] left_rd;
  logic [7:0] right_rd;
  logic [7:0] rd_mux;
  logic [7:0] rd_word;
  assign ctrl_rd = {ctrl_q.enable, ctrl_q.test, 2'b00, ctrl_q.align,
                    ctrl_q.signed_fmt, ctrl_q.wait_pd, ctrl_q.pin_oe};
  assign rsvd_rd = DACRC_ZERO;
  assign left_rd = view_left_live ? value_q : DACRC_ZERO;
  assign right_rd = view_right_live ? value_q : DACRC_ZERO;
  // selects are one-hot by construction, so an and-or mux is enough
  assign rd_mux = ({DACRC_DW{sel_ctrl}} & ctrl_rd)
                | ({DACRC_DW{sel_rsvd}} & rsvd_rd)
                | ({DACRC_DW{sel_left}} & left_rd)
                | ({DACRC_DW{sel_right}} & right_rd);
  // idle cycles return zero so a stale byte never looks like an answer
  assign rd_word = reg_rd ? rd_mux : DACRC_ZERO;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= DACRC_ZERO;
    end else begin
      reg_rdata <= rd_word;
    end
  end

  // ----------------------------------------
  // converter power state
  // ----------------------------------------
  dacrc_state_t state_q;
  dacrc_state_t state_d;
  logic low_power;
  logic want_off;
  assign low_power = stop_s || (wait_s && ctrl_q.wait_pd);
  assign want_off = !ctrl_q.enable;
  // every state obeys the same exits; hold only remembers why the core is down
  always_comb begin
    state_d = state_q;
    case (state_q)
      DACRC_OFF: begin
        if (want_off) begin
          state_d = DACRC_OFF;
        end else if (low_power) begin
          state_d = DACRC_HOLD;
        end else begin
          state_d = DACRC_RUN;
        end
      end
      DACRC_RUN: begin
        if (want_off) begin
          state_d = DACRC_OFF;
        end else if (low_power) begin
          state_d = DACRC_HOLD;
        end else begin
          state_d = DACRC_RUN;
        end
      end
      DACRC_HOLD: begin
        if (want_off) begin
          state_d = DACRC_OFF;
        end else if (low_power) begin
          state_d = DACRC_HOLD;
        end else begin
          state_d = DACRC_RUN;
        end
      end
      default: begin
        state_d = DACRC_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= DACRC_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // core drive
  // ----------------------------------------
  logic [7:0] code_w;
  dacrc_code u_code (
    .value(value_q),
    .signed_fmt(ctrl_q.signed_fmt),
    .code(code_w)
  );
  // next state is used so the core follows the register one cycle later
  logic run_w;
  assign run_w = (state_d == DACRC_RUN);
  dacrc_core_t core_d;
  dacrc_core_t core_q;
  assign core_d.code = code_w;
  assign core_d.power_up = run_w;
  assign core_d.pin_oe = run_w && ctrl_q.pin_oe;
  assign core_d.test = ctrl_q.test;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      core_q <= '0;
    end else begin
      core_q <= core_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign core_code = core_q.code;
  assign core_power_up = core_q.power_up;
  assign analog_output_pin_oe = core_q.pin_oe;
  assign core_test = core_q.test;
endmodule : dacrc_top

// ### dacrc_top_properties.sv
// Purpose: port checker for dacrc_top
// Assumes: mode inputs held three cycles before they count
// Notes: code checks need a control write then a value write
`timescale 1ns/1ps
module dacrc_props
  import dacrc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [DACRC_AW-1:0] reg_addr,
  input wire logic [DACRC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DACRC_DW-1:0] reg_rdata,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic [7:0] core_code,
  input wire logic core_power_up,
  input wire logic core_test,
  input wire logic analog_output_pin_oe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic ctl_wr = reg_wr && reg_addr == DACRC_OFS_CTRL;
  // sync latency: a mode only counts once it has stood three edges
  wire logic quiet = !stop_mode && !wait_mode;
  property p_rsvd; reg_rd && reg_addr == DACRC_OFS_RSVD |=> reg_rdata == DACRC_ZERO; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_gap; reg_rd && reg_addr == DACRC_OFS_CTRL |=> reg_rdata[5:4] == 2'h0; endproperty
  a_gap: assert property (p_gap) else $error("control bits 5:4 not zero");
  property p_oe; analog_output_pin_oe |-> core_power_up; endproperty
  a_oe: assert property (p_oe) else $error("pin driven while off");
  property p_off; ctl_wr && !reg_wdata[7] |-> ##2 !core_power_up && !analog_output_pin_oe; endproperty
  a_off: assert property (p_off) else $error("core on after disable");
  property p_on; quiet[*3] ##0 (ctl_wr && reg_wdata[7] && reg_wdata[0])
    |-> ##2 core_power_up && analog_output_pin_oe; endproperty
  a_on: assert property (p_on) else $error("core not started");
  property p_stop; stop_mode[*3] |=> !core_power_up; endproperty
  a_stop: assert property (p_stop) else $error("core on in stop");
  property p_test; special_mode[*3] ##0 (ctl_wr && reg_wdata[6]) |-> ##2 core_test; endproperty
  a_test: assert property (p_test) else $error("test bit not set");
  property p_sgn;
    logic [7:0] v;
    (ctl_wr && reg_wdata == 8'h84) ##1 (reg_wr && reg_addr == DACRC_OFS_LEFT, v = reg_wdata)
      |-> ##2 core_code == (v ^ 8'h80);
  endproperty
  a_sgn: assert property (p_sgn) else $error("signed code wrong");
  c_sgn: cover property (ctl_wr && reg_wdata == 8'h84);
  c_stop: cover property (stop_mode[*3]);
  c_test: cover property (special_mode ##0 ctl_wr);
endmodule : dacrc_props
bind dacrc_top dacrc_props u_props (.*);

// ### tb_dacrc_top.sv
// Purpose: self-checking bench for dacrc_top
// Assumes: inputs driven on rising edges
// Notes: a refused write keeps the old bit, so test stays set
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dacrc_top
  import dacrc_pkg::*;
;
  logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  logic special_mode = 0, wait_mode = 0, stop_mode = 0;
  logic [DACRC_AW-1:0] reg_addr = '0;
  logic [DACRC_DW-1:0] reg_wdata = '0;
  logic [DACRC_DW-1:0] reg_rdata;
  logic [7:0] core_code;
  logic core_power_up, core_test, analog_output_pin_oe;
  int failures = 0, cmp_count = 0;
  dacrc_top dut (.*);
  initial forever #20 ref_clk = ~ref_clk;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // wr leaves the strobe up so writes can run back to back
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    `CHK(reg_rdata, e)
    @(posedge ref_clk);
  endtask : rd
  task automatic cyc(input int n);
    reg_wr <= 1'h0;
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic core(input logic p, input logic o, input logic t, input logic [7:0] c);
    @(negedge ref_clk);
    `CHK({core_power_up, analog_output_pin_oe, core_test, core_code}, {p, o, t, c})
    @(posedge ref_clk);
  endtask : core
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'h1;
    cyc(4);
    rd(0, 8'h00);
    core(0, 0, 0, 8'h00);
    $display("test reset done");
    wr(0, 8'hFF);
    rd(0, 8'h8F);
    core(1, 1, 0, 8'h80);
    wait_mode <= 1'h1;
    cyc(3);
    core(0, 0, 0, 8'h80);
    wait_mode <= 1'h0;
    $display("test control done");
    wr(0, 8'h81);
    wr(2, 8'hA5);
    wr(3, 8'h11);
    rd(2, 8'hA5);
    rd(3, 8'h00);
    core(1, 1, 0, 8'hA5);
    wr(0, 8'h89);
    rd(3, 8'hA5);
    rd(2, 8'h00);
    wr(2, 8'h22);
    rd(3, 8'hA5);
    $display("test align done");
    wr(0, 8'h8D);
    wr(3, 8'h7F);
    cyc(1);
    core(1, 1, 0, 8'hFF);
    wr(3, 8'h80);
    cyc(1);
    core(1, 1, 0, 8'h00);
    wr(0, 8'h84);
    wr(2, 8'h01);
    cyc(1);
    core(1, 0, 0, 8'h81);
    $display("test signed done");
    wr(1, 8'hFF);
    rd(1, 8'h00);
    rd(0, 8'h84);
    $display("test reserved done");
    special_mode <= 1'h1;
    cyc(4);
    wr(0, 8'hC1);
    rd(0, 8'hC1);
    core(1, 1, 1, 8'h01);
    special_mode <= 1'h0;
    cyc(4);
    wr(0, 8'h01);
    rd(0, 8'h41);
    core(0, 0, 1, 8'h01);
    $display("test special done");
    wr(0, 8'h81);
    stop_mode <= 1'h1;
    cyc(3);
    core(0, 0, 1, 8'h01);
    rd(0, 8'hC1);
    stop_mode <= 1'h0;
    $display("test stop done");
    arst_n <= 1'h0;
    cyc(2);
    arst_n <= 1'h1;
    cyc(4);
    rd(0, 8'h00);
    rd(2, 8'h00);
    core(0, 0, 0, 8'h00);
    $display("test rereset done");
    conclude();
  end
endmodule : tb_dacrc_top
